// [design/conv_mode_ctrl.sv]
// Pin-driven mode controller of a delta-sigma converter: readout, standby, calibration, power-down.
// Assumes the host drives serial_shift_clock, power_down_n and rate_select asynchronously.
//
// Summary of operation
// - Wake from that standby starts offset calibration.
// - Data ready 103 or 803 ms after wake.
// - First result after calibration is valid.
// - Intervals scale with converter clock period.
// - Power-down shuts off the analog circuitry (analog_enable); the converter-clock tick divider keeps running.
// - Power-down resets the mode, counter and readout logic; the pin synchronizers and tick divider keep running.
// - Power-down abandons any partial readback.
// - Wake after power-down per clock source.
// - Ready low, then MSB first per rise.
// - Pulse 25 drives high; 26th fall calibrates.
// - Output stays high through standby until ready.
`timescale 1ns/1ns
`default_nettype none
module conv_mode_ctrl
  import conv_mode_pkg::*;
#(
  parameter int CONV_FAST = CONV_FAST_CONV_CYC,
  parameter int CONV_SLOW = CONV_SLOW_CONV_CYC,
  parameter int CAL_FAST = CAL_FAST_CONV_CYC,
  parameter int CAL_SLOW = CAL_SLOW_CONV_CYC,
  parameter int STBY_FAST = STBY_FAST_CONV_CYC,
  parameter int STBY_SLOW = STBY_SLOW_CONV_CYC,
  parameter int WAKE_XTAL = WAKE_XTAL_CONV_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Host pins.
  input wire logic serial_shift_clock,
  input wire logic power_down_n,
  input wire logic rate_select,
  // Configuration and data.
  input wire conv_mode_pkg::clk_src_e clk_source,
  input wire logic [23:0] sample_data,
  // Outputs.
  output logic data_ready_serial_out,
  output logic analog_enable,
  output logic calibrating
);
  import conv_mode_pkg::*;

  typedef enum logic [2:0] {ST_OFF, ST_WAKE, ST_CONV, ST_READY, ST_STBY, ST_CAL} mode_e;

  logic [2:0] sclk_sync_ff;
  logic [1:0] pdn_sync_ff;
  logic [1:0] rate_sync_ff;
  logic tick;
  logic sclk_rise;
  logic sclk_fall;
  mode_e mode_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [4:0] pulses_ff;
  logic [23:0] shift_ff;
  logic cal_pend_ff;
  logic [CNT_W-1:0] conv_left_ff;
  logic pd;

  function automatic logic [CNT_W-1:0] pick(input logic fast, input int f, input int s);
    pick = fast ? CNT_W'(f) : CNT_W'(s);
  endfunction

  function automatic logic [CNT_W-1:0] wake_len(input clk_src_e src);
    unique case (src)
      CLK_INTERNAL: wake_len = CNT_W'(WAKE_INT_CONV_CYC);
      CLK_EXTERNAL: wake_len = CNT_W'(WAKE_EXT_CONV_CYC);
      CLK_CRYSTAL: wake_len = CNT_W'(WAKE_XTAL);
      default: wake_len = CNT_W'(WAKE_XTAL);
    endcase
  endfunction

  conv_tick_div #(.DIV(SYS_PER_CONV_CYC)) u_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sclk_sync_ff <= 3'h0;
      pdn_sync_ff <= 2'h0;
      rate_sync_ff <= 2'h0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], serial_shift_clock};
      pdn_sync_ff <= {pdn_sync_ff[0], power_down_n};
      rate_sync_ff <= {rate_sync_ff[0], rate_select};
    end
  end

  assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
  assign pd = ~pdn_sync_ff[1];

  // Mode sequencing; power-down overrides everything and clears all state.
  always_ff @(posedge sys_clk) begin
    if (reset || pd) begin
      mode_ff <= ST_OFF;
      cnt_ff <= '0;
      cal_pend_ff <= 1'b0;
    end else begin
      unique case (mode_ff)
        ST_OFF: begin
          mode_ff <= ST_WAKE;
          cnt_ff <= wake_len(clk_source);
        end
        ST_WAKE, ST_CONV, ST_CAL: begin
          if (tick) begin
            if (cnt_ff <= CNT_W'(1)) begin
              mode_ff <= (mode_ff == ST_WAKE) ? ST_CONV : ST_READY;
              cnt_ff <= pick(rate_sync_ff[1], CONV_FAST, CONV_SLOW);
              cal_pend_ff <= 1'b0;
            end else begin
              cnt_ff <= cnt_ff - CNT_W'(1);
            end
          end
        end
        ST_READY: begin
          if (sclk_fall && pulses_ff == 5'(CAL_PLAIN_PULSES)) begin
            mode_ff <= ST_CAL;
            cnt_ff <= pick(rate_sync_ff[1], CAL_FAST, CAL_SLOW);
          end else if (sclk_sync_ff[1] && tick) begin
            if (cnt_ff <= CNT_W'(1)) begin
              mode_ff <= ST_STBY;
              cal_pend_ff <= (pulses_ff == 5'(CAL_REQ_PULSES));
            end else begin
              cnt_ff <= cnt_ff - CNT_W'(1);
            end
          end else if (!sclk_sync_ff[1] && conv_left_ff == '0) begin
            mode_ff <= ST_CONV;
            cnt_ff <= CNT_W'(1);
          end else if (!sclk_sync_ff[1]) begin
            cnt_ff <= pick(rate_sync_ff[1], STBY_FAST, STBY_SLOW);
          end
        end
        ST_STBY: begin
          if (sclk_fall) begin
            mode_ff <= cal_pend_ff ? ST_CAL : ST_CONV;
            cnt_ff <= cal_pend_ff ? pick(rate_sync_ff[1], CAL_FAST, CAL_SLOW)
                                  : pick(rate_sync_ff[1], CONV_FAST, CONV_SLOW);
          end
        end
        default: mode_ff <= ST_OFF;
      endcase
    end
  end

  // Conversions keep running while a result waits, so an unread result is replaced.
  always_ff @(posedge sys_clk) begin
    if (reset || pd || mode_ff != ST_READY) begin
      conv_left_ff <= pick(rate_sync_ff[1], CONV_FAST, CONV_SLOW);
    end else if (tick && conv_left_ff != '0) begin
      conv_left_ff <= conv_left_ff - CNT_W'(1);
    end
  end

  // Readout shifter; a new result loads on entry to ready and is valid after calibration.
  always_ff @(posedge sys_clk) begin
    if (reset || pd || mode_ff != ST_READY) begin
      pulses_ff <= 5'h00;
      shift_ff <= sample_data;
    end else if (sclk_rise && pulses_ff != 5'h1f) begin
      pulses_ff <= pulses_ff + 5'h01;
      if (pulses_ff != 5'h00) begin
        shift_ff <= {shift_ff[22:0], 1'b1};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || pd || mode_ff != ST_READY) begin
      data_ready_serial_out <= 1'b1;
    end else if (pulses_ff == 5'h00) begin
      data_ready_serial_out <= 1'b0;
    end else if (pulses_ff <= 5'(DATA_BITS)) begin
      data_ready_serial_out <= shift_ff[23];
    end else begin
      data_ready_serial_out <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      analog_enable <= 1'b0;
      calibrating <= 1'b0;
    end else begin
      analog_enable <= !pd && mode_ff != ST_OFF && mode_ff != ST_STBY;
      calibrating <= !pd && mode_ff == ST_CAL;
    end
  end

  AST_PD_CLEARS: assert property (@(posedge sys_clk) disable iff (reset)
    pd |=> (mode_ff == ST_OFF && !cal_pend_ff))
    else $error("Power-down did not clear the mode state.");

  AST_PD_OUT_HIGH: assert property (@(posedge sys_clk) disable iff (reset)
    (pd && $past(pd)) |-> data_ready_serial_out)
    else $error("Output not released high during power-down.");

  AST_PD_ANALOG_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    (pd && $past(pd)) |-> !analog_enable)
    else $error("Analog circuitry enabled in power-down.");

  AST_STBY_HIGH: assert property (@(posedge sys_clk) disable iff (reset || pd)
    (mode_ff == ST_STBY) |=> data_ready_serial_out)
    else $error("Output low during standby.");

  AST_CAL_WAKE: assert property (@(posedge sys_clk) disable iff (reset || pd)
    (mode_ff == ST_STBY && cal_pend_ff && sclk_fall) |=> mode_ff == ST_CAL)
    else $error("Wake from calibration standby did not calibrate.");

  AST_CAL_LOAD: assert property (@(posedge sys_clk) disable iff (reset || pd)
    (mode_ff == ST_STBY && cal_pend_ff && sclk_fall && rate_sync_ff[1])
    |=> cnt_ff == CNT_W'(CAL_FAST))
    else $error("Calibration interval wrong for fast rate.");

  AST_READY_LOW: assert property (@(posedge sys_clk) disable iff (reset || pd)
    $rose(mode_ff == ST_READY) |=> !data_ready_serial_out)
    else $error("Ready not signalled low.");

  AST_PULSE25_HIGH: assert property (@(posedge sys_clk) disable iff (reset || pd)
    (mode_ff == ST_READY && pulses_ff == 5'(CAL_REQ_PULSES)) |=> data_ready_serial_out)
    else $error("Pulse 25 did not force output high.");

  AST_TICK_COUNT: assert property (@(posedge sys_clk) disable iff (reset || pd)
    (mode_ff == ST_CAL && !tick && $past(mode_ff) == ST_CAL) |=> $stable(cnt_ff) || mode_ff != ST_CAL)
    else $error("Interval counted without converter tick.");
endmodule // conv_mode_ctrl
`default_nettype wire

// [design/conv_mode_pkg.sv]
// Constants for the converter mode controller: standby, wake-up calibration and power-down.
// Assumes a 25 MHz system clock; converter timing scales with the converter clock period.
package conv_mode_pkg;
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int CONV_CLK_HZ = 4_915_200;
  localparam int SYS_PER_CONV_CYC = (SYS_CLK_HZ + CONV_CLK_HZ - 1) / CONV_CLK_HZ;
  localparam int DATA_BITS = 24;
  localparam int CAL_REQ_PULSES = 25;
  localparam int CAL_PLAIN_PULSES = 26;
  localparam int CAL_FAST_MS = 103;
  localparam int CAL_SLOW_MS = 803;
  localparam int CAL_FAST_CONV_CYC = CAL_FAST_MS * (CONV_CLK_HZ / 1000) + (CAL_FAST_MS * 200) / 1000;
  localparam int CAL_SLOW_CONV_CYC = CAL_SLOW_MS * (CONV_CLK_HZ / 1000) + (CAL_SLOW_MS * 200) / 1000;
  localparam int STBY_FAST_CONV_CYC = 61_244;
  localparam int STBY_SLOW_CONV_CYC = 491_324;
  localparam int CONV_FAST_CONV_CYC = 61_440;
  localparam int CONV_SLOW_CONV_CYC = 491_520;
  localparam int WAKE_INT_NS = 7950;
  localparam int WAKE_EXT_NS = 160;
  localparam int WAKE_XTAL_US = 5600;
  localparam int WAKE_INT_CONV_CYC = (WAKE_INT_NS * 49_152) / 10_000_000;
  localparam int WAKE_EXT_CONV_CYC = 1;
  localparam int WAKE_XTAL_CONV_CYC = (WAKE_XTAL_US * 49_152) / 10_000;
  localparam int CNT_W = 22;
  typedef enum logic [1:0] {CLK_INTERNAL, CLK_EXTERNAL, CLK_CRYSTAL} clk_src_e;
endpackage

// [design/conv_tick_div.sv]
// Divider making a one-cycle converter-clock enable from the system clock.
// Assumes a single system clock and synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module conv_tick_div #(
  parameter int DIV = 6
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Enable out.
  output logic tick
);
  logic [7:0] cnt_ff;

  always_ff @(posedge sys_clk) begin
    if (reset || cnt_ff == 8'(DIV - 1)) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_ff == 8'(DIV - 1));
    end
  end
endmodule // conv_tick_div
`default_nettype wire

// [testbench/conv_host_model.sv]
// Host model: drives shift clock, power-down and rate pins and reads the serial result.
// Assumes the bench calls its tasks; pins change on the falling edge of sys_clk.
`timescale 1ns/1ns
`default_nettype none
module conv_host_model (
  // Clock.
  input wire logic sys_clk,
  // Pins to the converter.
  output logic serial_shift_clock,
  output logic power_down_n,
  output logic rate_select,
  // Pin from the converter.
  input wire logic data_ready_serial_out
);
  initial begin
    serial_shift_clock = 1'b0;
    power_down_n = 1'b0;
    rate_select = 1'b1;
  end
  // Pulses of 160 ns high every 320 ns; each bit is taken just before the next rise, long after it settles.
  task automatic shift(input int n, input bit hold, output logic [23:0] word);
    word = 24'h0;
    for (int i = 1; i <= n; i++) begin
      @(negedge sys_clk) serial_shift_clock = 1'b1;
      repeat (4) @(negedge sys_clk);
      if (!(hold && i == n)) begin
        serial_shift_clock = 1'b0;
        repeat (3) @(negedge sys_clk);
        if (i <= 24) word = {word[22:0], data_ready_serial_out};
      end
    end
  endtask
  task automatic wake();
    @(negedge sys_clk) serial_shift_clock = 1'b0;
  endtask
  task automatic pins(input logic pd_n, input logic rate);
    @(negedge sys_clk);
    power_down_n = pd_n;
    rate_select = rate;
  endtask
endmodule // conv_host_model
`default_nettype wire

// [testbench/adc_standby_cal_powerdown_ctrl_bench.sv]
// Bench for the converter mode controller: readout, standby with calibration, power-down.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module adc_standby_cal_powerdown_ctrl_bench;
  import conv_mode_pkg::*;
  localparam int CAL_F = 20;
  localparam int CAL_S = 40;
  localparam int STBY = 20;
  localparam int CONV = 100;
  localparam int WAKE_X = 20;
  logic sys_clk, reset, serial_shift_clock, power_down_n, rate_select;
  logic data_ready_serial_out, analog_enable, calibrating;
  clk_src_e clk_source;
  logic [23:0] sample_data, word;
  int miscompares = 0;
  int checked = 0;
  int n;
  conv_host_model host_u (.sys_clk(sys_clk), .serial_shift_clock(serial_shift_clock),
    .power_down_n(power_down_n), .rate_select(rate_select),
    .data_ready_serial_out(data_ready_serial_out));
  conv_mode_ctrl #(.CONV_FAST(CONV), .CONV_SLOW(CONV), .CAL_FAST(CAL_F), .CAL_SLOW(CAL_S),
    .STBY_FAST(STBY), .STBY_SLOW(STBY), .WAKE_XTAL(WAKE_X)) dut_u (.sys_clk(sys_clk),
    .reset(reset), .serial_shift_clock(serial_shift_clock), .power_down_n(power_down_n),
    .rate_select(rate_select), .clk_source(clk_source), .sample_data(sample_data),
    .data_ready_serial_out(data_ready_serial_out), .analog_enable(analog_enable),
    .calibrating(calibrating));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic compare_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic compare_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wait_ready(input int bound, output int cyc);
    cyc = 0;
    while (data_ready_serial_out !== 1'b0 && cyc < bound) begin
      @(negedge sys_clk);
      cyc++;
    end
    if (cyc >= bound) begin
      miscompares++;
      $display("Error ready wait expected 0 seen %b", data_ready_serial_out);
      results();
    end
  endtask
  task automatic read_word();
    wait_ready(4000, n);
    compare_bit("analog on", 1'b1, analog_enable);
    host_u.shift(25, 1'b0, word);
    compare_word("word", sample_data, word);
    compare_bit("line after 25", 1'b1, data_ready_serial_out);
  endtask
  // Hold selects standby entry; without it the 26th pulse's fall starts calibration.
  task automatic standby_cal(input logic r, input int cal, input int pulses, input bit hold);
    host_u.pins(1'b1, r);
    wait_ready(4000, n);
    host_u.shift(pulses, hold, word);
    if (hold) begin
      repeat (STBY * 6 + 60) @(negedge sys_clk);
      compare_bit("standby line", 1'b1, data_ready_serial_out);
      compare_bit("standby analog", 1'b0, analog_enable);
      host_u.wake();
    end
    repeat (8) @(negedge sys_clk);
    compare_bit("calibrating", pulses >= 25, calibrating);
    wait_ready(cal * 6 + 100, n);
    n = n + (hold ? 0 : 3);
    compare_bit("cal time", 1'b1, n >= cal * 6 - 12 && n <= cal * 6 + 12);
    read_word();
  endtask
  task automatic power_down(input clk_src_e src, input int wake);
    clk_source = src;
    wait_ready(4000, n);
    host_u.shift(10, 1'b0, word);
    host_u.pins(1'b0, 1'b1);
    repeat (8) @(negedge sys_clk);
    compare_bit("pd analog", 1'b0, analog_enable);
    compare_bit("pd line", 1'b1, data_ready_serial_out);
    compare_bit("pd cal", 1'b0, calibrating);
    host_u.pins(1'b1, 1'b1);
    wait_ready(4000, n);
    compare_bit("wake time", 1'b1, n >= (wake + CONV) * 6 - 12 && n <= (wake + CONV) * 6 + 12);
    read_word();
  endtask
  initial begin
    reset = 1'b1;
    clk_source = CLK_INTERNAL;
    sample_data = 24'ha5c396;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    host_u.pins(1'b1, 1'b1);
    read_word();
    read_word();
    sample_data = 24'h5a3c69;
    standby_cal(1'b1, CAL_F, 25, 1'b1);
    standby_cal(1'b0, CAL_S, 25, 1'b1);
    standby_cal(1'b1, CAL_F, 26, 1'b0);
    standby_cal(1'b1, CONV, 10, 1'b1);
    power_down(CLK_INTERNAL, WAKE_INT_CONV_CYC);
    power_down(CLK_EXTERNAL, WAKE_EXT_CONV_CYC);
    power_down(CLK_CRYSTAL, WAKE_X);
    results();
  end
endmodule // adc_standby_cal_powerdown_ctrl_bench
`default_nettype wire
